// >>> hw/ubrk_pkg.sv
// constants and types shared by the user break comparator
package ubrk_pkg;
    localparam int          UBRK_IDX_W      = 30;
    localparam int          UBRK_NUM_CFG    = 5;
    localparam logic [29:0] UBRK_DEC_MASK   = 30'h0F0001FF;
    localparam logic [29:0] UBRK_IDX_ADDR_H = 30'h05FFFF90;
    localparam logic [29:0] UBRK_IDX_ADDR_L = 30'h05FFFF92;
    localparam logic [29:0] UBRK_IDX_MASK_H = 30'h05FFFF94;
    localparam logic [29:0] UBRK_IDX_MASK_L = 30'h05FFFF96;
    localparam logic [29:0] UBRK_IDX_CYCLE  = 30'h05FFFF98;
    localparam logic [29:0] UBRK_IDX_STATUS = 30'h05FFFF9A;
    localparam logic [29:0] UBRK_IDX_IMASK  = 30'h05FFFF9C;
    localparam int          UBRK_CFG_ADDR_H = 0;
    localparam int          UBRK_CFG_ADDR_L = 1;
    localparam int          UBRK_CFG_MASK_H = 2;
    localparam int          UBRK_CFG_MASK_L = 3;
    localparam int          UBRK_CFG_CYCLE  = 4;
    localparam logic [15:0] UBRK_CFG_RESET  = 16'h0000;
    localparam logic [15:0] UBRK_CYCLE_BITS = 16'h00FF;
    localparam logic [15:0] UBRK_FULL_BITS  = 16'hFFFF;
    localparam int          UBRK_ORIGIN_HI  = 7;
    localparam int          UBRK_ORIGIN_LO  = 6;
    localparam int          UBRK_KIND_HI    = 5;
    localparam int          UBRK_KIND_LO    = 4;
    localparam int          UBRK_DIR_HI     = 3;
    localparam int          UBRK_DIR_LO     = 2;
    localparam int          UBRK_SIZE_LSB   = 0;
    localparam int          UBRK_NUM_STAT   = 3;
    localparam int          UBRK_ST_ANY     = 0;
    localparam int          UBRK_ST_CPU     = 1;
    localparam int          UBRK_ST_DMA     = 2;
    localparam logic [2:0]  UBRK_STAT_RESET = 3'h0;
    typedef enum logic [1:0] {
        UBRK_SZ_ANY,
        UBRK_SZ_BYTE,
        UBRK_SZ_WORD,
        UBRK_SZ_LONG
    } ubrk_size_type;
endpackage

// >>> hw/ubrk_comparator.sv
// user break comparator with apb register access and interrupt
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

//Contract
//- compare every processor or dma bus cycle against the break conditions
//- match on address, origin, fetch or data, direction and operand size
//- all programmed conditions met raises a break request
//- fetch break takes effect before the fetched instruction executes
//- five registers at consecutive halfword offsets, byte, halfword, longword access
//- decode only address bits 27..24 and 8..0
//- break address split into upper and lower 16-bit halves
//- reset clears address halves; standby leaves them alone
//- every address bit readable and writable, reset to zero
//- mask bit one drops that address bit from comparison
//- any origin, kind or direction pair at 00 blocks every break
//- pair codes 01 first type, 10 second type, 11 both
//- size 00 ignored, 01 byte, 10 word, 11 long; fetch is word
module ubrk_comparator
    import ubrk_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        CYC_VALID_I,
    input  wire logic [31:0] CYC_ADDR_I,
    input  wire logic        CYC_DMA_I,
    input  wire logic        CYC_FETCH_I,
    input  wire logic        CYC_WRITE_I,
    input  wire logic [1:0]  CYC_SIZE_I,
    input  wire logic        BREAK_ACK_I,
    output logic             BREAK_REQ_O,
    output logic             IRQ_O
);

    logic [15:0]   cfg_q [UBRK_NUM_CFG];
    logic [2:0]    stat_q;
    logic [2:0]    stat_d;
    logic [2:0]    imask_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic          req_q;
    logic          irq_q;

    wire  [29:0]   idx       = PADDR_I[31:2];
    wire           done      = PSEL_I && PENABLE_I && pready_q;
    wire           wr_done   = done && PWRITE_I;
    wire           rd_done   = done && !PWRITE_I;
    wire  [15:0]   lane_mask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

    // only the significant address lines take part; the rest alias freely
    wire  [29:0]   idx_sig   = idx & UBRK_DEC_MASK;
    wire  [29:0]   cfg_idx [UBRK_NUM_CFG];
    wire  [15:0]   cfg_bits [UBRK_NUM_CFG];
    wire  [UBRK_NUM_CFG-1:0] cfg_hit;
    wire           stat_hit  = idx_sig == (UBRK_IDX_STATUS & UBRK_DEC_MASK);
    wire           imask_hit = idx_sig == (UBRK_IDX_IMASK & UBRK_DEC_MASK);
    wire           mapped    = (|cfg_hit) || stat_hit || imask_hit;

    assign cfg_idx[UBRK_CFG_ADDR_H]  = UBRK_IDX_ADDR_H;
    assign cfg_idx[UBRK_CFG_ADDR_L]  = UBRK_IDX_ADDR_L;
    assign cfg_idx[UBRK_CFG_MASK_H]  = UBRK_IDX_MASK_H;
    assign cfg_idx[UBRK_CFG_MASK_L]  = UBRK_IDX_MASK_L;
    assign cfg_idx[UBRK_CFG_CYCLE]   = UBRK_IDX_CYCLE;
    assign cfg_bits[UBRK_CFG_ADDR_H] = UBRK_FULL_BITS;
    assign cfg_bits[UBRK_CFG_ADDR_L] = UBRK_FULL_BITS;
    assign cfg_bits[UBRK_CFG_MASK_H] = UBRK_FULL_BITS;
    assign cfg_bits[UBRK_CFG_MASK_L] = UBRK_FULL_BITS;
    // upper byte of the cycle register is reserved and reads zero
    assign cfg_bits[UBRK_CFG_CYCLE]  = UBRK_CYCLE_BITS;

    genvar gi;
    generate
        for (gi = 0; gi < UBRK_NUM_CFG; gi++) begin : g_cfg
            assign cfg_hit[gi] = idx_sig == (cfg_idx[gi] & UBRK_DEC_MASK);
            // byte lanes let byte, halfword and longword writes all land
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    cfg_q[gi] <= UBRK_CFG_RESET;
                end else if (wr_done && cfg_hit[gi]) begin
                    cfg_q[gi] <= ((PWDATA_I[15:0] & lane_mask) | (cfg_q[gi] & ~lane_mask))
                                 & cfg_bits[gi];
                end
            end
        end
    endgenerate

    // address comparison over the two halves with per-bit ignore
    wire  [31:0]   brk_addr  = {cfg_q[UBRK_CFG_ADDR_H], cfg_q[UBRK_CFG_ADDR_L]};
    wire  [31:0]   brk_mask  = {cfg_q[UBRK_CFG_MASK_H], cfg_q[UBRK_CFG_MASK_L]};
    wire  [15:0]   sel       = cfg_q[UBRK_CFG_CYCLE];
    wire           addr_ok   = &(~(CYC_ADDR_I ^ brk_addr) | brk_mask);
    wire           origin_ok = CYC_DMA_I ? sel[UBRK_ORIGIN_HI] : sel[UBRK_ORIGIN_LO];
    wire           kind_ok   = CYC_FETCH_I ? sel[UBRK_KIND_LO] : sel[UBRK_KIND_HI];
    wire           dir_ok    = CYC_WRITE_I ? sel[UBRK_DIR_HI] : sel[UBRK_DIR_LO];
    wire  [1:0]    size_sel  = sel[UBRK_SIZE_LSB +: 2];
    // fetches are word cycles whatever the bus reports
    wire  [1:0]    eff_size  = CYC_FETCH_I ? UBRK_SZ_WORD : CYC_SIZE_I;
    wire           size_ok   = (size_sel == UBRK_SZ_ANY) || (size_sel == eff_size);
    // a 00 pair yields zero from both legs of its select, so it blocks alone
    wire           cyc_match = CYC_VALID_I && addr_ok && origin_ok
                               && kind_ok && dir_ok && size_ok;

    // hardware set beats a clearing read in the same cycle
    wire  [2:0]    stat_set  = {cyc_match && CYC_DMA_I, cyc_match && !CYC_DMA_I, cyc_match};
    wire           stat_clr  = rd_done && stat_hit;
    assign stat_d = (stat_clr ? UBRK_STAT_RESET : stat_q) | stat_set;
    wire  [2:0]    imask_d   = (wr_done && imask_hit && PSTRB_I[0]) ? PWDATA_I[2:0] : imask_q;

    wire  [15:0]   cfg_rd    = cfg_hit[UBRK_CFG_ADDR_H] ? cfg_q[UBRK_CFG_ADDR_H] :
                               cfg_hit[UBRK_CFG_ADDR_L] ? cfg_q[UBRK_CFG_ADDR_L] :
                               cfg_hit[UBRK_CFG_MASK_H] ? cfg_q[UBRK_CFG_MASK_H] :
                               cfg_hit[UBRK_CFG_MASK_L] ? cfg_q[UBRK_CFG_MASK_L] :
                               cfg_hit[UBRK_CFG_CYCLE]  ? cfg_q[UBRK_CFG_CYCLE]  : 16'h0000;
    wire  [31:0]   rd_word   = stat_hit  ? {29'h0, stat_q}  :
                               imask_hit ? {29'h0, imask_q} : {16'h0, cfg_rd};

    // one wait state so read data and answer come from flip-flops
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= PSEL_I && PENABLE_I && !pready_q;
            pslverr_q <= PSEL_I && PENABLE_I && !pready_q && !mapped;
            prdata_q  <= (PSEL_I && PENABLE_I && !pready_q && !PWRITE_I) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            stat_q  <= UBRK_STAT_RESET;
            imask_q <= UBRK_STAT_RESET;
            irq_q   <= 1'b0;
        end else begin
            stat_q  <= stat_d;
            imask_q <= imask_d;
            // next mask too, so the level never lags a mask write by a cycle
            irq_q   <= |(stat_d & imask_d);
        end
    end

    // request registered on the matching cycle, before the fetched word can execute
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            req_q <= 1'b0;
        end else begin
            req_q <= cyc_match || (req_q && !BREAK_ACK_I);
        end
    end

    assign PRDATA_O    = prdata_q;
    assign PREADY_O    = pready_q;
    assign PSLVERR_O   = pslverr_q;
    assign BREAK_REQ_O = req_q;
    assign IRQ_O       = irq_q;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence s_apb_access;
        PSEL_I && PENABLE_I && !PREADY_O;
    endsequence

    sequence s_full_write_hi;
        PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && (PSTRB_I[1:0] == 2'h3)
        && cfg_hit[UBRK_CFG_ADDR_H];
    endsequence

    sequence s_fetch_hit;
        CYC_VALID_I && CYC_FETCH_I && cyc_match;
    endsequence

    sequence s_read_access;
        PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I;
    endsequence

    sequence s_write_done;
        PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    endsequence

    sequence s_status_read;
        PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && stat_hit;
    endsequence

    sequence s_bad_access;
        PSEL_I && PENABLE_I && !PREADY_O && !mapped;
    endsequence

    apb_answer_a: assert property (s_apb_access |=> PREADY_O ##1 !PREADY_O)
        else $error("apb answer not one wait state");

    addr_write_a: assert property (s_full_write_hi |=> cfg_q[UBRK_CFG_ADDR_H] == $past(PWDATA_I[15:0]))
        else $error("address half not written");

    break_match_a: assert property (cyc_match |=> BREAK_REQ_O)
        else $error("match did not raise request");

    fetch_break_a: assert property (s_fetch_hit |-> ##1 BREAK_REQ_O && stat_q[UBRK_ST_ANY])
        else $error("fetch break late");

    req_hold_a: assert property (BREAK_REQ_O && !BREAK_ACK_I |=> BREAK_REQ_O)
        else $error("request dropped before ack");

    req_clear_a: assert property (BREAK_REQ_O && BREAK_ACK_I && !cyc_match |=> !BREAK_REQ_O)
        else $error("request held after ack");

    idle_quiet_a: assert property (!CYC_VALID_I |-> !cyc_match)
        else $error("idle bus matched");

    pair_zero_a: assert property ((sel[7:6] == 2'h0 || sel[5:4] == 2'h0 || sel[3:2] == 2'h0)
                                  |-> !cyc_match)
        else $error("zero selector pair matched");

    mask_bit_a: assert property ((((CYC_ADDR_I ^ brk_addr) & ~brk_mask) != 32'h0) |-> !cyc_match)
        else $error("unmasked address bit ignored");

    fetch_word_a: assert property (CYC_FETCH_I && size_sel != UBRK_SZ_ANY
                                   && size_sel != UBRK_SZ_WORD |-> !cyc_match)
        else $error("fetch not treated as word");

    alias_decode_a: assert property (PSEL_I && ((idx ^ UBRK_IDX_CYCLE) & UBRK_DEC_MASK) == 30'h0
                                     |-> cfg_hit[UBRK_CFG_CYCLE])
        else $error("ignored address lines affected decode");

    irq_level_a: assert property (cyc_match && imask_d[UBRK_ST_ANY] |=> IRQ_O && stat_q[UBRK_ST_ANY])
        else $error("masked-in event gave no interrupt");

    err_unmapped_a: assert property (s_bad_access |=> PREADY_O && PSLVERR_O)
        else $error("unmapped access gave no error");

    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");

    err_mapped_a: assert property (PSEL_I && PENABLE_I && !PREADY_O && mapped |=> !PSLVERR_O)
        else $error("mapped access flagged as error");

    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");

    ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
        else $error("ready without access phase");

    rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside answer cycle");

    rdata_upper_a: assert property (PRDATA_O[31:16] == 16'h0000)
        else $error("read data above halfword not zero");

    addr_hi_read_a: assert property (s_read_access ##0 cfg_hit[UBRK_CFG_ADDR_H]
                                     |=> PRDATA_O[15:0] == $past(brk_addr[31:16]))
        else $error("upper address half misread");

    addr_lo_read_a: assert property (s_read_access ##0 cfg_hit[UBRK_CFG_ADDR_L]
                                     |=> PRDATA_O[15:0] == $past(brk_addr[15:0]))
        else $error("lower address half misread");

    mask_lo_read_a: assert property (s_read_access ##0 cfg_hit[UBRK_CFG_MASK_L]
                                     |=> PRDATA_O[15:0] == $past(brk_mask[15:0]))
        else $error("lower mask half misread");

    cycle_read_a: assert property (s_read_access ##0 cfg_hit[UBRK_CFG_CYCLE]
                                   |=> PRDATA_O[15:0] == {8'h00, $past(sel[7:0])})
        else $error("cycle select misread");

    status_read_a: assert property (s_read_access ##0 stat_hit
                                    |=> PRDATA_O == {29'h0, $past(stat_q)})
        else $error("status misread");

    status_clear_a: assert property (s_status_read |=> stat_q == $past(stat_set))
        else $error("status not cleared by read");

    status_sticky_a: assert property (!stat_clr |=> (stat_q & $past(stat_q)) == $past(stat_q))
        else $error("status bit lost without read");

    irq_follow_a: assert property (IRQ_O == |(stat_q & imask_q))
        else $error("interrupt level disagrees with status");

    cpu_status_a: assert property (cyc_match && !CYC_DMA_I |=> stat_q[UBRK_ST_CPU])
        else $error("processor match not recorded");

    dma_status_a: assert property (cyc_match && CYC_DMA_I |=> stat_q[UBRK_ST_DMA])
        else $error("dma match not recorded");

    req_cause_a: assert property ($rose(BREAK_REQ_O) |-> $past(cyc_match))
        else $error("request rose without match");

    req_release_a: assert property ($fell(BREAK_REQ_O) |-> $past(BREAK_ACK_I))
        else $error("request fell without ack");

    origin_cpu_a: assert property (cyc_match && !CYC_DMA_I |-> sel[UBRK_ORIGIN_LO])
        else $error("processor cycle matched while deselected");

    origin_dma_a: assert property (cyc_match && CYC_DMA_I |-> sel[UBRK_ORIGIN_HI])
        else $error("dma cycle matched while deselected");

    kind_fetch_a: assert property (cyc_match && CYC_FETCH_I |-> sel[UBRK_KIND_LO])
        else $error("fetch matched while deselected");

    kind_data_a: assert property (cyc_match && !CYC_FETCH_I |-> sel[UBRK_KIND_HI])
        else $error("data access matched while deselected");

    dir_read_a: assert property (cyc_match && !CYC_WRITE_I |-> sel[UBRK_DIR_LO])
        else $error("read matched while deselected");

    dir_write_a: assert property (cyc_match && CYC_WRITE_I |-> sel[UBRK_DIR_HI])
        else $error("write matched while deselected");

    size_data_a: assert property (cyc_match && !CYC_FETCH_I && size_sel != UBRK_SZ_ANY
                                  |-> size_sel == CYC_SIZE_I)
        else $error("data size mismatch matched");

    size_long_a: assert property (cyc_match && size_sel == UBRK_SZ_LONG
                                  |-> !CYC_FETCH_I && CYC_SIZE_I == UBRK_SZ_LONG)
        else $error("longword break on other size");

    imask_write_a: assert property (s_write_done ##0 (imask_hit && PSTRB_I[0])
                                    |=> imask_q == $past(PWDATA_I[2:0]))
        else $error("interrupt mask not written");

    lane_keep_a: assert property (s_write_done ##0 (cfg_hit[UBRK_CFG_ADDR_L] && !PSTRB_I[1])
                                  |=> brk_addr[15:8] == $past(brk_addr[15:8]))
        else $error("unstrobed lane changed");

    lane_write_a: assert property (s_write_done ##0 (cfg_hit[UBRK_CFG_ADDR_L] && PSTRB_I[0])
                                   |=> brk_addr[7:0] == $past(PWDATA_I[7:0]))
        else $error("strobed lane not written");

    mask_write_a: assert property (s_write_done ##0 (cfg_hit[UBRK_CFG_MASK_L] && PSTRB_I[1:0] == 2'h3)
                                   |=> brk_mask[15:0] == $past(PWDATA_I[15:0]))
        else $error("mask half not written");

    cycle_write_a: assert property (s_write_done ##0 (cfg_hit[UBRK_CFG_CYCLE] && PSTRB_I[0])
                                    |=> sel[7:0] == $past(PWDATA_I[7:0]))
        else $error("cycle select not written");

    cycle_reserved_a: assert property (sel[15:8] == 8'h00)
        else $error("reserved cycle bits set");

    cfg_hold_a: assert property (!wr_done |=> $stable(brk_addr) && $stable(brk_mask) && $stable(sel))
        else $error("condition register changed without write");

    write_drop_a: assert property (wr_done && !mapped
                                   |=> $stable(brk_addr) && $stable(brk_mask) && $stable(sel) && $stable(imask_q))
        else $error("unmapped write landed");

endmodule

// >>> dv/ubrk_far_model.sv
// partner model: bus cycle source and interrupt controller acknowledge
`timescale 1ns/1ps
module ubrk_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [36:0] cyc_i,
    input  wire logic [2:0]  ack_wait_i,
    input  wire logic        break_req_i,
    output logic             cyc_valid_o,
    output logic      [36:0] cyc_o,
    output logic             break_ack_o
);
    logic [2:0] wait_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_valid_o <= 1'b0;
            cyc_o       <= '0;
            break_ack_o <= 1'b0;
            wait_q      <= 3'h0;
        end else begin
            cyc_valid_o <= go_i;
            // idle fields toggle so stale values never look valid
            cyc_o <= go_i ? cyc_i : ~cyc_o;
            if (break_req_i && !break_ack_o) begin
                // slow or prompt acknowledge of the held level
                break_ack_o <= (wait_q == ack_wait_i);
                wait_q      <= (wait_q == ack_wait_i) ? 3'h0 : wait_q + 3'h1;
            end else begin
                break_ack_o <= 1'b0;
            end
        end
    end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the user break comparator
`timescale 1ns/1ps
module testbench import ubrk_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r, s = 32'h44FA;
    logic [3:0]  pstrb = '0;
    logic [2:0]  ackw = '0;
    logic [36:0] cyc = '0, co;
    logic        pready, pslverr, cv, ack, req, irq, e;
    logic [15:0] mdl;
    int          errors = 0, tests_run = 0;

    always #20 clk = ~clk;

    ubrk_comparator dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CYC_VALID_I(cv), .CYC_ADDR_I(co[36:5]), .CYC_DMA_I(co[4]), .CYC_FETCH_I(co[3]),
        .CYC_WRITE_I(co[2]), .CYC_SIZE_I(co[1:0]), .BREAK_ACK_I(ack), .BREAK_REQ_O(req), .IRQ_O(irq));
    ubrk_far_model far (.clk_i(clk), .rst_i(rst), .go_i(go), .cyc_i(cyc), .ack_wait_i(ackw),
        .break_req_i(req), .cyc_valid_o(cv), .cyc_o(co), .break_ack_o(ack));

    function automatic logic [31:0] nx();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic end_of_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [29:0] ix, input logic [31:0] d, input logic [3:0] st);
        int n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {ix, 2'b00};
        pwdata  <= d;
        pstrb   <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
    endtask

    initial begin
        logic [31:0] v, a, w, ca;
        logic [7:0]  bb;
        logic [2:0]  im, st;
        logic [1:0]  sz;
        logic        m;
        int          n;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, UBRK_IDX_ADDR_H + 30'(2 * i), 32'h0, 4'h0);
            chk(r, 32'h0);
        end
        apb(1'b0, 30'h05FFFF91, 32'h0, 4'h0);
        chk({r[30:0], e}, 32'h1);
        // full write through an alias, then one byte lane only
        for (int i = 0; i < 5; i++) begin
            v = nx();
            apb(1'b1, (UBRK_IDX_ADDR_H + 30'(2 * i)) & ~30'h00FFFE00, v, 4'hF);
            apb(1'b1, UBRK_IDX_ADDR_H + 30'(2 * i), ~v, 4'h2);
            mdl = {~v[15:8], v[7:0]} & ((i == 4) ? UBRK_CYCLE_BITS : UBRK_FULL_BITS);
            apb(1'b0, UBRK_IDX_ADDR_H + 30'(2 * i), 32'h0, 4'h0);
            chk(r, {16'h0000, mdl});
        end
        apb(1'b1, UBRK_IDX_MASK_H, 32'h0, 4'hF);
        for (int k = 0; k < 250; k++) begin
            v  = nx();
            a  = nx();
            w  = nx();
            bb = w[17:10];
            im = w[20:18];
            sz = (w[6:5] == 2'b00) ? 2'b10 : w[6:5];
            ca = v ^ {15'h0000, a[8], a[15:0] & a[31:16]};
            m  = (w[0] | w[1]) && bb[6 + w[2]] && bb[5 - w[3]] && bb[2 + w[4]]
                 && (bb[1:0] == 2'b00 || bb[1:0] == (w[3] ? 2'b10 : sz))
                 && (((ca ^ v) & ~{16'h0000, a[31:16]}) == 32'h0);
            st = {w[2] & m, ~w[2] & m, m};
            apb(1'b1, UBRK_IDX_ADDR_H, v >> 16, 4'hF);
            apb(1'b1, UBRK_IDX_ADDR_L, v, 4'hF);
            apb(1'b1, UBRK_IDX_MASK_L, a >> 16, 4'hF);
            apb(1'b1, UBRK_IDX_CYCLE, {24'h0, bb}, 4'hF);
            apb(1'b1, UBRK_IDX_IMASK, {29'h0, im}, 4'hF);
            @(posedge clk);
            go   <= w[0] | w[1];
            cyc  <= {ca, w[2], w[3], w[4], sz};
            ackw <= w[9:7];
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            #1;
            chk({31'h0, req}, {31'h0, m});
            chk({31'h0, irq}, {31'h0, |(st & im)});
            apb(1'b0, UBRK_IDX_STATUS, 32'h0, 4'h0);
            chk(r, {29'h0, st});
            apb(1'b0, UBRK_IDX_STATUS, 32'h0, 4'h0);
            #1;
            chk(r | {31'h0, irq}, 32'h0);
            n = 0;
            while (req !== 1'b0 && n < 20) begin
                @(posedge clk);
                n++;
            end
            chk({31'h0, req}, 32'h0);
            if (req !== 1'b0) end_of_test();
        end
        // second reset in mid-run must clear every register again
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({30'h0, req, irq}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, UBRK_IDX_ADDR_H + 30'(2 * i), 32'h0, 4'h0);
            chk(r, 32'h0);
        end
        end_of_test();
    end
endmodule
